// file: hw/smbus_port_regs.vh
// Overview of operation
// - A clock-low interval longer than the timeout window abandons the transaction as an error.
// - With idle-reset disable cleared, both lines high over 50 ms reset any transaction.
// - As master the port clocks the bus at a typical 51.2 kHz.
// - Total slave clock-low stretching per message stays within 25 ms.
// - Total master clock-low extension per message stays within 10 ms.
// - Master clock low at least 4.7 us, high at least 4 us; high over 50 us is bus idle.
// - At least 4.7 us of bus free time separates a stop from the next start.
// - Both lines low for 2 s or more enters the bus-off state.
// - Either line going high leaves bus-off and the bus is usable within 1 ms.
// - Both lines low for a programmable minimum time starts offset auto-calibration.
// - The port follows bus protocol revision 1.1 with master mode and packet error checking.
// - As master the port broadcasts charging current and charging voltage to the charger.
`ifndef SMBUS_PORT_REGS_VH
`define SMBUS_PORT_REGS_VH
`define CLK_MHZ          100
`define TIMEOUT_US       30
`define TIMEOUT_CYC      (`TIMEOUT_US * `CLK_MHZ)
`define IDLE_MS          50
`define IDLE_CYC         (`IDLE_MS * 1000 * `CLK_MHZ)
`define BUSOFF_MS        2000
`define BUSOFF_CYC       (`BUSOFF_MS * 1000 * `CLK_MHZ)
`define READY_US         500
`define READY_CYC        (`READY_US * `CLK_MHZ)
`define SEXT_MS          25
`define SEXT_CYC         (`SEXT_MS * 1000 * `CLK_MHZ)
`define MEXT_MS          10
`define MEXT_CYC         (`MEXT_MS * 1000 * `CLK_MHZ)
`define HALF_NS          9766
`define HALF_CYC         ((`HALF_NS * `CLK_MHZ) / 1000)
`define TLOW_NS          4700
`define TBUF_NS          4700
`define TBUF_CYC         ((`TBUF_NS * `CLK_MHZ + 999) / 1000)
`define THIGH_NS         4000
`define BUS_IDLE_US      50
`define BUS_IDLE_CYC     (`BUS_IDLE_US * `CLK_MHZ)
`define CHG_CMD_CURRENT  8'h14
`define CHG_CMD_VOLTAGE  8'h15
`define CHARGER_ADDR_W   8'h12
`endif

// file: hw/bus_condition_timer.v
`timescale 1ns/1ps
// Counts how long a condition holds; restarts when it breaks.
module bus_condition_timer #(
    parameter WIDTH = 32,
    parameter LIMIT = 100
) (
    // Clock and reset
    input  wire             i_mclk,
    input  wire             i_reset,
    // Condition
    input  wire             i_cond,
    // Result
    output reg              o_hit
);
    reg [WIDTH-1:0] count_ff;

    always @(posedge i_mclk or posedge i_reset)
    begin
        if (i_reset)
        begin
            count_ff <= {WIDTH{1'b0}};
            o_hit    <= 1'b0;
        end
        else if (!i_cond)
        begin
            count_ff <= {WIDTH{1'b0}};
            o_hit    <= 1'b0;
        end
        else if (count_ff != LIMIT[WIDTH-1:0])
        begin
            count_ff <= count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
            o_hit    <= 1'b0;
        end
        else
        begin
            o_hit    <= 1'b1;
        end
    end
endmodule // bus_condition_timer

// file: hw/smbus_port_supervisor.v
`timescale 1ns/1ps
`include "smbus_port_regs.vh"
module smbus_port_supervisor #(
    parameter IDLE_CYC   = `IDLE_CYC,
    parameter BUSOFF_CYC = `BUSOFF_CYC,
    parameter SEXT_CYC   = `SEXT_CYC,
    parameter MEXT_CYC   = `MEXT_CYC,
    parameter READY_CYC  = `READY_CYC,
    parameter CAL_W      = 32
) (
    // Clock and reset
    input  wire             i_mclk,
    input  wire             i_reset,
    // Bus pins (oe low = driving low)
    input  wire             i_bus_clock_line,
    input  wire             i_bus_data_line,
    output wire             o_bus_clock_line,
    output reg              o_bus_clock_line_oe,
    output wire             o_bus_data_line,
    output reg              o_bus_data_line_oe,
    // Control
    input  wire             i_idle_reset_disable_bit,
    input  wire [CAL_W-1:0] i_cal_min_cyc,
    input  wire             i_slave_stretch,
    // Broadcast request
    input  wire             i_bcast_start,
    input  wire [15:0]      i_chg_current,
    input  wire [15:0]      i_chg_voltage,
    output wire             o_bcast_busy,
    // Status
    output reg              o_timeout,
    output reg              o_txn_reset,
    output reg              o_bus_off,
    output reg              o_bus_ready,
    output reg              o_cal_start,
    output reg              o_ext_fault
);
    localparam ST_IDLE  = 3'd0;
    localparam ST_START = 3'd1;
    localparam ST_LOW   = 3'd2;
    localparam ST_HIGH  = 3'd3;
    localparam ST_STOP  = 3'd4;
    localparam ST_BUF   = 3'd5;
    localparam [15:0] HALF = `HALF_CYC;
    localparam [15:0] TBUF = `TBUF_CYC;
    localparam [15:0] TOUT = `TIMEOUT_CYC;
    localparam [15:0] BIDL = `BUS_IDLE_CYC;

    // Synchronisers
    reg [1:0] scl_sync_ff;
    reg [1:0] sda_sync_ff;
    reg       scl_prev_ff;
    reg       sda_prev_ff;
    wire      scl = scl_sync_ff[1];
    wire      sda = sda_sync_ff[1];

    always @(posedge i_mclk or posedge i_reset)
    begin
        if (i_reset)
        begin
            scl_sync_ff <= 2'b11;
            sda_sync_ff <= 2'b11;
            scl_prev_ff <= 1'b1;
            sda_prev_ff <= 1'b1;
        end
        else
        begin
            scl_sync_ff <= {scl_sync_ff[0], i_bus_clock_line};
            sda_sync_ff <= {sda_sync_ff[0], i_bus_data_line};
            scl_prev_ff <= scl;
            sda_prev_ff <= sda;
        end
    end

    wire start_seen = scl && scl_prev_ff && sda_prev_ff && !sda;
    wire stop_seen  = scl && scl_prev_ff && !sda_prev_ff && sda;

    // Message framing on the wire
    reg in_msg_ff;
    always @(posedge i_mclk or posedge i_reset)
    begin
        if (i_reset)
            in_msg_ff <= 1'b0;
        else if (stop_seen || o_txn_reset || o_timeout)
            in_msg_ff <= 1'b0;
        else if (start_seen)
            in_msg_ff <= 1'b1;
    end

    // Clock-low timeout
    reg [15:0] low_cnt_ff;
    always @(posedge i_mclk or posedge i_reset)
    begin
        if (i_reset)
        begin
            low_cnt_ff <= 16'h0000;
            o_timeout  <= 1'b0;
        end
        else
        begin
            low_cnt_ff <= scl ? 16'h0000 : (low_cnt_ff == TOUT ? TOUT : low_cnt_ff + 16'h0001);
            o_timeout  <= in_msg_ff && !scl && (low_cnt_ff == TOUT - 16'h0001);
        end
    end

    // Long-duration condition timers
    wire idle_hit;
    wire off_hit;
    wire both_low = !scl && !sda;

    bus_condition_timer #(.WIDTH(32), .LIMIT(IDLE_CYC)) u_idle (
        .i_mclk  (i_mclk),
        .i_reset (i_reset),
        .i_cond  (scl && sda && !i_idle_reset_disable_bit),
        .o_hit   (idle_hit)
    );
    bus_condition_timer #(.WIDTH(32), .LIMIT(BUSOFF_CYC)) u_off (
        .i_mclk  (i_mclk),
        .i_reset (i_reset),
        .i_cond  (both_low),
        .o_hit   (off_hit)
    );

    // Calibration trigger uses a runtime limit
    reg [CAL_W-1:0] cal_cnt_ff;
    reg             cal_done_ff;
    always @(posedge i_mclk or posedge i_reset)
    begin
        if (i_reset)
        begin
            cal_cnt_ff  <= {CAL_W{1'b0}};
            cal_done_ff <= 1'b0;
            o_cal_start <= 1'b0;
        end
        else if (!both_low)
        begin
            cal_cnt_ff  <= {CAL_W{1'b0}};
            cal_done_ff <= 1'b0;
            o_cal_start <= 1'b0;
        end
        else
        begin
            if (cal_cnt_ff != i_cal_min_cyc)
                cal_cnt_ff <= cal_cnt_ff + {{(CAL_W-1){1'b0}}, 1'b1};
            o_cal_start <= !cal_done_ff && (cal_cnt_ff == i_cal_min_cyc);
            if (cal_cnt_ff == i_cal_min_cyc)
                cal_done_ff <= 1'b1;
        end
    end
    // Idle transaction reset pulse
    reg idle_prev_ff;
    always @(posedge i_mclk or posedge i_reset)
    begin
        if (i_reset)
        begin
            idle_prev_ff <= 1'b0;
            o_txn_reset  <= 1'b0;
        end
        else
        begin
            idle_prev_ff <= idle_hit;
            o_txn_reset  <= idle_hit && !idle_prev_ff;
        end
    end

    // Bus-off and recovery
    reg [31:0] rdy_cnt_ff;
    always @(posedge i_mclk or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_bus_off   <= 1'b0;
            o_bus_ready <= 1'b1;
            rdy_cnt_ff  <= 32'h0000_0000;
        end
        else if (off_hit)
        begin
            o_bus_off   <= 1'b1;
            o_bus_ready <= 1'b0;
            rdy_cnt_ff  <= 32'h0000_0000;
        end
        else if (o_bus_off)
        begin
            o_bus_off   <= 1'b0;
        end
        else if (!o_bus_ready)
        begin
            // Recovery finishes well inside the 1 ms window
            if (rdy_cnt_ff == READY_CYC[31:0])
                o_bus_ready <= 1'b1;
            else
                rdy_cnt_ff <= rdy_cnt_ff + 32'h0000_0001;
        end
    end

    // Cumulative clock-extend policing per message
    reg [31:0] sext_ff;
    reg [31:0] mext_ff;
    reg        master_ff;
    always @(posedge i_mclk or posedge i_reset)
    begin
        if (i_reset)
        begin
            sext_ff     <= 32'h0000_0000;
            mext_ff     <= 32'h0000_0000;
            o_ext_fault <= 1'b0;
        end
        else if (!in_msg_ff)
        begin
            sext_ff     <= 32'h0000_0000;
            mext_ff     <= 32'h0000_0000;
            o_ext_fault <= 1'b0;
        end
        else
        begin
            if (i_slave_stretch && !scl)
                sext_ff <= sext_ff + 32'h0000_0001;
            if (!master_ff && !scl && low_cnt_ff > HALF)
                mext_ff <= mext_ff + 32'h0000_0001;
            if (sext_ff >= SEXT_CYC[31:0] || mext_ff >= MEXT_CYC[31:0])
                o_ext_fault <= 1'b1;
        end
    end

    // Master broadcast engine: address, command, two data bytes, PEC
    reg [2:0]  state_ff;
    reg [15:0] tcnt_ff;
    reg [3:0]  bit_ff;
    reg [2:0]  byte_ff;
    reg [7:0]  shift_ff;
    reg [7:0]  pec_ff;
    reg        phase_ff;
    reg        scl_drv_ff;
    reg        sda_drv_ff;
    reg [31:0] bus_idle_cnt_ff;

    function [7:0] crc8_step;
        input [7:0] crc;
        input [7:0] data;
        integer     k;
        reg   [7:0] c;
        begin
            c = crc ^ data;
            for (k = 0; k < 8; k = k + 1)
                c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
            crc8_step = c;
        end
    endfunction

    function [7:0] frame_byte;
        input [2:0]  idx;
        input        volt;
        input [15:0] cur;
        input [15:0] vlt;
        input [7:0]  pec;
        begin
            case (idx)
                3'd0:    frame_byte = `CHARGER_ADDR_W;
                3'd1:    frame_byte = volt ? `CHG_CMD_VOLTAGE : `CHG_CMD_CURRENT;
                3'd2:    frame_byte = volt ? vlt[7:0] : cur[7:0];
                3'd3:    frame_byte = volt ? vlt[15:8] : cur[15:8];
                default: frame_byte = pec;
            endcase
        end
    endfunction

    assign o_bus_clock_line = 1'b0;
    assign o_bus_data_line  = 1'b0;
    assign o_bcast_busy     = (state_ff != ST_IDLE);

    always @(posedge i_mclk or posedge i_reset)
    begin
        if (i_reset)
            bus_idle_cnt_ff <= 32'h0000_0000;
        else if (!(scl && sda) || in_msg_ff)
            bus_idle_cnt_ff <= 32'h0000_0000;
        else if (bus_idle_cnt_ff != {16'h0000, BIDL})
            bus_idle_cnt_ff <= bus_idle_cnt_ff + 32'h0000_0001;
    end

    always @(posedge i_mclk or posedge i_reset)
    begin
        if (i_reset)
        begin
            state_ff            <= ST_IDLE;
            tcnt_ff             <= 16'h0000;
            bit_ff              <= 4'd0;
            byte_ff             <= 3'd0;
            shift_ff            <= 8'h00;
            pec_ff              <= 8'h00;
            phase_ff            <= 1'b0;
            master_ff           <= 1'b0;
            o_bus_clock_line_oe <= 1'b1;
            o_bus_data_line_oe  <= 1'b1;
        end
        else
        begin
            tcnt_ff <= tcnt_ff + 16'h0001;
            case (state_ff)
                ST_IDLE:
                begin
                    master_ff           <= 1'b0;
                    o_bus_clock_line_oe <= 1'b1;
                    o_bus_data_line_oe  <= 1'b1;
                    if (i_bcast_start && o_bus_ready && !o_bus_off
                        && bus_idle_cnt_ff == {16'h0000, BIDL})
                    begin
                        state_ff  <= ST_START;
                        tcnt_ff   <= 16'h0000;
                        phase_ff  <= 1'b0;
                        master_ff <= 1'b1;
                    end
                end
                ST_START:
                begin
                    o_bus_data_line_oe <= 1'b0;
                    if (tcnt_ff == HALF)
                    begin
                        state_ff <= ST_LOW;
                        tcnt_ff  <= 16'h0000;
                        byte_ff  <= 3'd0;
                        bit_ff   <= 4'd0;
                        pec_ff   <= crc8_step(8'h00, `CHARGER_ADDR_W);
                        shift_ff <= `CHARGER_ADDR_W;
                        o_bus_clock_line_oe <= 1'b0;
                    end
                end
                ST_LOW:
                begin
                    o_bus_clock_line_oe <= 1'b0;
                    // Data changes one cycle after the clock falls; ninth bit released for ack
                    o_bus_data_line_oe  <= (bit_ff == 4'd8) ? 1'b1 : shift_ff[7];
                    if (tcnt_ff == HALF)
                    begin
                        state_ff <= ST_HIGH;
                        tcnt_ff  <= 16'h0000;
                        o_bus_clock_line_oe <= 1'b1;
                    end
                end
                ST_HIGH:
                begin
                    // Stretching slave keeps the count cleared to zero until clock rises
                    if (!scl)
                        tcnt_ff <= 16'h0000;
                    else if (tcnt_ff == HALF)
                    begin
                        state_ff <= ST_LOW;
                        tcnt_ff  <= 16'h0000;
                        o_bus_clock_line_oe <= 1'b0;
                        if (bit_ff == 4'd8)
                        begin
                            bit_ff <= 4'd0;
                            if (byte_ff == 3'd4 || sda)
                                state_ff <= ST_STOP;
                            else
                            begin
                                byte_ff  <= byte_ff + 3'd1;
                                shift_ff <= frame_byte(byte_ff + 3'd1, phase_ff,
                                                       i_chg_current, i_chg_voltage, pec_ff);
                                if (byte_ff != 3'd3)
                                    pec_ff <= crc8_step(pec_ff, frame_byte(byte_ff + 3'd1,
                                              phase_ff, i_chg_current, i_chg_voltage, pec_ff));
                            end
                        end
                        else
                        begin
                            bit_ff   <= bit_ff + 4'd1;
                            shift_ff <= {shift_ff[6:0], 1'b0};
                        end
                    end
                end
                ST_STOP:
                begin
                    o_bus_data_line_oe <= 1'b0;
                    if (tcnt_ff == HALF)
                        o_bus_clock_line_oe <= 1'b1;
                    if (tcnt_ff == HALF + HALF)
                    begin
                        o_bus_data_line_oe <= 1'b1;
                        state_ff <= ST_BUF;
                        tcnt_ff  <= 16'h0000;
                    end
                end
                ST_BUF:
                begin
                    if (tcnt_ff == TBUF)
                    begin
                        tcnt_ff <= 16'h0000;
                        if (!phase_ff)
                        begin
                            phase_ff <= 1'b1;
                            state_ff <= ST_START;
                        end
                        else
                            state_ff <= ST_IDLE;
                    end
                end
                default:
                    state_ff <= ST_IDLE;
            endcase
            if (o_timeout || o_txn_reset || o_bus_off)
                state_ff <= ST_IDLE;
        end
    end
endmodule // smbus_port_supervisor

// file: sim/smbus_port_supervisor_checker.sv
`timescale 1ns/1ps
module smbus_port_supervisor_checker #(
    parameter IDLE_CYC   = 2000,
    parameter BUSOFF_CYC = 5000,
    parameter CAL_W      = 32
) (
    // Clock and reset
    input wire             i_mclk,
    input wire             i_reset,
    // Bus
    input wire             i_bus_clock_line,
    input wire             i_bus_data_line,
    input wire             o_bus_clock_line_oe,
    input wire             o_bus_data_line_oe,
    // Control and status
    input wire             i_idle_reset_disable_bit,
    input wire [CAL_W-1:0] i_cal_min_cyc,
    input wire             o_bcast_busy,
    input wire             o_timeout,
    input wire             o_txn_reset,
    input wire             o_bus_off,
    input wire             o_bus_ready,
    input wire             o_cal_start,
    input wire             o_ext_fault
);
    // Raw pin counters run ahead of the design's synchronisers
    reg [31:0] hi_cnt_ff;
    reg [31:0] lo_cnt_ff;
    reg [31:0] clo_cnt_ff;
    reg [31:0] mlo_cnt_ff;
    reg [31:0] stp_cnt_ff;
    reg        scl_ff;
    reg        sda_ff;
    wire       stop_seen = scl_ff & i_bus_clock_line & ~sda_ff & i_bus_data_line;

    always @(posedge i_mclk or posedge i_reset)
    begin
        if (i_reset)
        begin
            hi_cnt_ff  <= 32'h0;
            lo_cnt_ff  <= 32'h0;
            clo_cnt_ff <= 32'h0;
            mlo_cnt_ff <= 32'h0;
            stp_cnt_ff <= 32'h1000;
            scl_ff     <= 1'b1;
            sda_ff     <= 1'b1;
        end
        else
        begin
            hi_cnt_ff  <= (i_bus_clock_line & i_bus_data_line) ? hi_cnt_ff + 32'h1 : 32'h0;
            lo_cnt_ff  <= (!i_bus_clock_line && !i_bus_data_line) ? lo_cnt_ff + 32'h1 : 32'h0;
            clo_cnt_ff <= i_bus_clock_line ? 32'h0 : clo_cnt_ff + 32'h1;
            mlo_cnt_ff <= o_bus_clock_line_oe ? 32'h0 : mlo_cnt_ff + 32'h1;
            stp_cnt_ff <= stop_seen ? 32'h0 : stp_cnt_ff + 32'h1;
            scl_ff     <= i_bus_clock_line;
            sda_ff     <= i_bus_data_line;
        end
    end

    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_reset);

    idle_reset_time_a: assert property (
        $rose(o_txn_reset) |-> hi_cnt_ff >= IDLE_CYC && !i_idle_reset_disable_bit)
        else $error("transaction reset before bus idle time");
    idle_reset_off_a: assert property (
        i_idle_reset_disable_bit && $past(i_idle_reset_disable_bit, 4) |-> !o_txn_reset)
        else $error("transaction reset while disabled");
    timeout_window_a: assert property (
        $rose(o_timeout) |-> clo_cnt_ff >= 2500 && clo_cnt_ff <= 3500)
        else $error("timeout outside 25 to 35 us");
    busoff_enter_a: assert property (lo_cnt_ff == BUSOFF_CYC + 6 |-> o_bus_off)
        else $error("bus off missing after long low");
    busoff_early_a: assert property ($rose(o_bus_off) |-> lo_cnt_ff >= BUSOFF_CYC)
        else $error("bus off too early");
    busoff_leave_a: assert property (
        o_bus_off && (i_bus_clock_line || i_bus_data_line) |-> ##[1:4] !o_bus_off)
        else $error("bus off kept after line rose");
    ready_back_a: assert property ($fell(o_bus_off) |-> ##[1:1000] o_bus_ready)
        else $error("bus not ready in time");
    cal_start_a: assert property ($rose(o_cal_start) |-> lo_cnt_ff >= i_cal_min_cyc)
        else $error("calibration started too early");
    cal_pulse_a: assert property (o_cal_start |=> !o_cal_start [*8])
        else $error("calibration start repeated");
    master_low_a: assert property (
        $rose(o_bus_clock_line_oe) |-> mlo_cnt_ff >= 470 && mlo_cnt_ff <= 1000)
        else $error("master clock low period out of range");
    bus_free_a: assert property (
        $fell(o_bus_data_line_oe) && i_bus_clock_line && o_bcast_busy |-> stp_cnt_ff >= 470)
        else $error("start too soon after stop");

    cover property ($rose(o_txn_reset));
    cover property ($rose(o_bus_off));
    cover property ($rose(o_cal_start));
    cover property ($rose(o_ext_fault));
    cover property ($rose(o_timeout));
endmodule // smbus_port_supervisor_checker

bind smbus_port_supervisor smbus_port_supervisor_checker #(
    .IDLE_CYC(IDLE_CYC), .BUSOFF_CYC(BUSOFF_CYC), .CAL_W(CAL_W)
) u_checker (
    .i_mclk(i_mclk), .i_reset(i_reset),
    .i_bus_clock_line(i_bus_clock_line), .i_bus_data_line(i_bus_data_line),
    .o_bus_clock_line_oe(o_bus_clock_line_oe), .o_bus_data_line_oe(o_bus_data_line_oe),
    .i_idle_reset_disable_bit(i_idle_reset_disable_bit), .i_cal_min_cyc(i_cal_min_cyc),
    .o_bcast_busy(o_bcast_busy), .o_timeout(o_timeout), .o_txn_reset(o_txn_reset),
    .o_bus_off(o_bus_off), .o_bus_ready(o_bus_ready), .o_cal_start(o_cal_start),
    .o_ext_fault(o_ext_fault)
);

// file: sim/charger_model.sv
`timescale 1ns/1ps
module charger_model #(
    parameter ACK_DLY = 300
) (
    // Bus wires
    input  wire i_scl,
    input  wire i_sda,
    // Data pull, low while driving
    output reg  o_sda_oe
);
    reg [7:0] shift_ff;
    reg [7:0] got [0:31];
    integer   bit_cnt;
    integer   byte_cnt;

    initial
    begin
        o_sda_oe = 1'b1;
        bit_cnt  = 0;
        byte_cnt = 0;
    end

    // Start or stop realigns the bit position, so no ack outlives a message
    always @(i_sda)
        if (i_scl)
            bit_cnt = 0;

    always @(posedge i_scl)
    begin
        if (bit_cnt < 8)
            shift_ff = {shift_ff[6:0], i_sda};
        bit_cnt = bit_cnt + 1;
        if (bit_cnt == 8)
        begin
            got[byte_cnt % 32] = shift_ff;
            byte_cnt = byte_cnt + 1;
        end
        if (bit_cnt == 9)
            bit_cnt = 0;
    end

    // Slow acknowledge: pulled 300 ns into the ninth low phase, never stretches the clock
    always @(negedge i_scl)
        o_sda_oe <= #(ACK_DLY) (bit_cnt != 8);
endmodule // charger_model

// file: sim/smbus_port_supervisor_tb.sv
`timescale 1ns/1ps
module smbus_port_supervisor_tb;
    localparam IDLE = 2000;
    localparam BOFF = 5000;
    localparam RDY  = 500;
    reg         i_mclk;
    reg         i_reset;
    reg         host_scl;
    reg         host_sda;
    reg         dis;
    reg  [31:0] cal_min;
    reg         stretch;
    reg         bstart;
    reg  [15:0] cur;
    reg  [15:0] volt;
    wire        scl_o, sda_o, scl_oe, sda_oe, chg_oe;
    wire        busy, t_out, t_rst, b_off, b_rdy, cal, ext;
    wire        scl = host_scl & (scl_oe | scl_o);
    wire        sda = host_sda & (sda_oe | sda_o) & chg_oe;
    integer     errors, checks, cycles, n_to, n_tr, n_cal, k, i;
    reg  [7:0]  exp_b [0:4];

    smbus_port_supervisor #(
        .IDLE_CYC(IDLE), .BUSOFF_CYC(BOFF), .SEXT_CYC(3000),
        .MEXT_CYC(2000), .READY_CYC(RDY), .CAL_W(32)
    ) dut (
        .i_mclk(i_mclk), .i_reset(i_reset),
        .i_bus_clock_line(scl), .i_bus_data_line(sda),
        .o_bus_clock_line(scl_o), .o_bus_clock_line_oe(scl_oe),
        .o_bus_data_line(sda_o), .o_bus_data_line_oe(sda_oe),
        .i_idle_reset_disable_bit(dis), .i_cal_min_cyc(cal_min),
        .i_slave_stretch(stretch), .i_bcast_start(bstart),
        .i_chg_current(cur), .i_chg_voltage(volt), .o_bcast_busy(busy),
        .o_timeout(t_out), .o_txn_reset(t_rst), .o_bus_off(b_off),
        .o_bus_ready(b_rdy), .o_cal_start(cal), .o_ext_fault(ext)
    );

    charger_model #(.ACK_DLY(300)) charger (.i_scl(scl), .i_sda(sda), .o_sda_oe(chg_oe));

    initial
    begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    task give_verdict;
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge i_mclk)
    begin
        cycles = cycles + 1;
        n_to   = n_to + (t_out === 1'b1);
        n_tr   = n_tr + (t_rst === 1'b1);
        n_cal  = n_cal + (cal === 1'b1);
        if (cycles == 125000)
        begin
            errors = errors + 1;
            give_verdict;
        end
    end

    task chk(input string name, input [31:0] seen, input [31:0] exp);
        checks = checks + 1;
        if (seen !== exp)
        begin
            errors = errors + 1;
            $display("FAIL %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task cyc(input integer n);
        repeat (n) @(posedge i_mclk);
    endtask

    task bus(input c, input d);
        @(posedge i_mclk);
        host_scl <= c;
        host_sda <= d;
    endtask

    task start_msg;
        bus(1, 1); cyc(50); bus(1, 0); cyc(50); bus(0, 0);
    endtask

    task stop_msg;
        bus(0, 0); cyc(50); bus(1, 0); cyc(50); bus(1, 1);
    endtask

    // Host link clock of 125 ns, built from 6 and 7 cycle halves
    task toggle(input integer n);
        for (i = 0; i < n; i = i + 1)
        begin
            bus(1, 0); cyc(5); bus(0, 0); cyc(5 + i % 2);
        end
    endtask

    task t_idle;
        k = n_tr;
        start_msg; stop_msg;
        cyc(IDLE - 30);
        chk("idle early", n_tr - k, 0);
        cyc(80);
        chk("idle reset", n_tr - k, 1);
        @(posedge i_mclk) dis <= 1'b1;
        start_msg; stop_msg;
        k = n_tr;
        cyc(IDLE + 200);
        chk("idle disabled", n_tr - k, 0);
        @(posedge i_mclk) dis <= 1'b0;
    endtask

    task t_timeout;
        k = n_to;
        start_msg; toggle(8); cyc(2000);
        chk("short low", n_to - k, 0);
        toggle(8);
        cyc(2500);
        chk("master ext", ext, 1);
        cyc(700);
        chk("timeout", n_to - k, 1);
        stop_msg;
    endtask

    task t_ext;
        start_msg;
        @(posedge i_mclk) stretch <= 1'b1;
        toggle(200);
        chk("ext early", ext, 0);
        toggle(320);
        chk("ext fault", ext, 1);
        @(posedge i_mclk) stretch <= 1'b0;
        stop_msg;
    endtask

    task t_busoff;
        k = n_cal;
        bus(0, 1); bus(0, 0); cyc(900);
        chk("cal early", n_cal - k, 0);
        cyc(200);
        chk("cal start", n_cal - k, 1);
        cyc(BOFF - 1200);
        chk("bus off early", b_off, 0);
        cyc(130);
        chk("bus off", b_off, 1);
        chk("cal once", n_cal - k, 1);
        bus(0, 1); cyc(6);
        chk("bus off left", b_off, 0);
        chk("not ready", b_rdy, 0);
        cyc(RDY + 10);
        chk("ready", b_rdy, 1);
        bus(1, 1);
    endtask

    function [7:0] crc8(input [31:0] d);
        integer   j;
        reg [7:0] c;
        c = 8'h00;
        for (j = 31; j >= 0; j = j - 1)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[j]) ? 8'h07 : 8'h00);
        crc8 = c;
    endfunction

    task t_bcast;
        exp_b[0] = 8'h12; exp_b[1] = 8'h14; exp_b[2] = cur[7:0]; exp_b[3] = cur[15:8];
        exp_b[4] = crc8({exp_b[0], exp_b[1], exp_b[2], exp_b[3]});
        cyc(5100);
        k = charger.byte_cnt;
        @(posedge i_mclk) bstart <= 1'b1;
        @(posedge i_mclk) bstart <= 1'b0;
        #1 chk("busy", busy, 1);
        for (i = 0; i < 100000 && charger.byte_cnt < k + 5; i = i + 1)
            cyc(1);
        for (i = 0; i < 5; i = i + 1)
            chk("frame byte", charger.got[(k + i) % 32], exp_b[i]);
        cyc(20);
        chk("voltage pending", busy, 1);
        cyc(300);
        @(posedge i_mclk) i_reset <= 1'b1;
        cyc(2);
        chk("abort", {scl_oe, sda_oe, busy}, 3'h6);
        @(posedge i_mclk) i_reset <= 1'b0;
    endtask

    initial
    begin
        errors = 0; checks = 0; cycles = 0; n_to = 0; n_tr = 0; n_cal = 0;
        i_reset = 1'b1; host_scl = 1'b1; host_sda = 1'b1; dis = 1'b0;
        cal_min = 32'h3E8; stretch = 1'b0; bstart = 1'b0;
        cur = 16'hA5C3; volt = 16'h3A10;
        cyc(3);
        chk("reset", {scl_oe, sda_oe, t_out, t_rst, b_off, b_rdy, cal, ext, busy}, 9'h188);
        @(posedge i_mclk) i_reset <= 1'b0;
        t_idle;
        t_timeout;
        t_ext;
        t_busoff;
        t_bcast;
        give_verdict;
    end
endmodule // smbus_port_supervisor_tb
